// file: core/pdm_edge_latch.sv
// Edge detector with a sticky request latch for one interrupt pin
`timescale 1ns/1ps
`default_nettype none
module pdm_edge_latch (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       pin_sync,
  input  wire logic [1:0] edge_sel,
  input  wire logic       clear,
  output logic            pending
);
  logic prev;
  wire  rise  = pin_sync & ~prev;
  wire  fall  = ~pin_sync & prev;
  wire  event_hit = (edge_sel[1] & rise) | (edge_sel[0] & fall);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // Idle pin level is high, so no false edge follows reset
      prev    <= 1'b1;
      pending <= 1'b0;
    end else if (ce) begin
      prev <= pin_sync;
      if (event_hit) begin // RULE18
        pending <= 1'b1;
      end else if (clear) begin
        pending <= 1'b0;
      end
    end
  end

  a_pending_set: assert property (@(posedge clock) disable iff (rst)
    ce && event_hit |=> pending) // RULE15
    else $error("edge not latched");
endmodule
`default_nettype wire

// file: core/pdm_port_mux.sv
// Port D/E pin-function mux with slave-port and serial-clock pin routing
// Functional notes
// RULE1 - Every bit of both ports has its own direction control.
// RULE2 - Port D bits can be push-pull or open-drain per bit.
// RULE3 - Output data passes holding registers loaded on a timer event.
// RULE4 - Port D bit 6 and 4 can carry serial A and B transmit data.
// RULE5 - Port D bits 7 and 5 feed serial A and B receive; software sets inputs.
// RULE6 - Each port E line can become an I/O strobe individually.
// RULE7 - A strobe fires only for external I/O in its eighth of 64K.
// RULE8 - Each strobe is chip select, write, read or read-and-write.
// RULE9 - Software sets strobe bits as outputs or the pin stays quiet.
// RULE10 - Slave port enabled: port E bit 7 is active-low slave select.
// RULE11 - Software keeps port E bit 7 an input when used as select.
// RULE12 - Port E bit 7 output low keeps slave select asserted.
// RULE13 - Port E bits 0 and 4 request external interrupt 0.
// RULE14 - Port E bits 1 and 5 request external interrupt 1.
// RULE15 - Each interrupt input triggers on falling, rising or both edges.
// RULE16 - Two inputs of one interrupt are edge-detected apart, then ORed.
// RULE17 - Software sets interrupt source bits as inputs.
// RULE18 - Each interrupt pin has its own pending latch.
// RULE19 - Slave enabled: port B bit 7 drives active-low attention.
// RULE20 - Master pulses active-low read strobe on port B bit 3.
// RULE21 - Master pulses active-low write strobe on port B bit 2.
// RULE22 - Master gives two-bit register address on port B bits 4 and 5.
// RULE23 - Slave enabled: port A is the bidirectional slave data bus.
// RULE24 - Synchronous serial: port B bits 1 and 0 carry clocks A and B.
// RULE25 - Alternate functions drive the pin instead of the data register.
`timescale 1ns/1ps
`default_nettype none
module pdm_port_mux #(
  parameter int unsigned W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         timer_event,
  input  wire logic [W-1:0] pd_data,
  input  wire logic [W-1:0] pd_dir,
  input  wire logic [W-1:0] pd_od,
  input  wire logic [W-1:0] pd_timed,
  input  wire logic [W-1:0] pe_data,
  input  wire logic [W-1:0] pe_dir,
  input  wire logic [W-1:0] pe_timed,
  input  wire logic [W-1:0] pe_strobe_en,
  input  wire logic [15:0]  strobe_mode,
  input  wire logic         tx_a_alt_en,
  input  wire logic         tx_b_alt_en,
  input  wire logic         tx_a,
  input  wire logic         tx_b,
  input  wire logic         rx_a_alt_en,
  input  wire logic         rx_b_alt_en,
  input  wire logic         io_cycle,
  input  wire logic         io_read,
  input  wire logic         io_write,
  input  wire logic [15:0]  io_addr,
  input  wire logic [3:0]   irq_src_en,
  input  wire logic [7:0]   irq_edge,
  input  wire logic         irq0_ack,
  input  wire logic         irq1_ack,
  input  wire logic         slave_en,
  input  wire logic         slave_attention_req,
  input  wire logic [W-1:0] slave_dout,
  input  wire logic         slave_dout_en,
  input  wire logic         sync_a_en,
  input  wire logic         sync_b_en,
  input  wire logic         serial_a_clock_out,
  input  wire logic         serial_a_clock_oe,
  input  wire logic         serial_b_clock_out,
  input  wire logic         serial_b_clock_oe,
  input  wire logic [W-1:0] port_d_lines_in,
  input  wire logic [W-1:0] port_e_lines_in,
  input  wire logic [W-1:0] port_a_in,
  input  wire logic [5:0]   port_b_in,
  output logic [W-1:0]      port_d_lines_out,
  output logic [W-1:0]      port_d_lines_oe,
  output logic [W-1:0]      port_e_lines_out,
  output logic [W-1:0]      port_e_lines_oe,
  output logic [W-1:0]      port_a_out,
  output logic [W-1:0]      port_a_oe,
  output logic              slave_attention_n,
  output logic              serial_a_clock_pin_out,
  output logic              serial_a_clock_pin_oe,
  output logic              serial_b_clock_pin_out,
  output logic              serial_b_clock_pin_oe,
  output logic [W-1:0]      port_d_read,
  output logic [W-1:0]      port_e_read,
  output logic [W-1:0]      slave_data_in,
  output logic              slave_chip_select_n,
  output logic              slave_read_strobe_n,
  output logic              slave_write_strobe_n,
  output logic [1:0]        slave_reg_addr,
  output logic              serial_a_clock_in,
  output logic              serial_b_clock_in,
  output logic              rx_a,
  output logic              rx_b,
  output logic              irq0_pending,
  output logic              irq1_pending
);
  // Input synchronisers
  logic [W-1:0] d_s1, d_s2, e_s1, e_s2, a_s1, a_s2;
  logic [5:0]   b_s1, b_s2;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      d_s1 <= '0;
      d_s2 <= '0;
      e_s1 <= '1;
      e_s2 <= '1;
      a_s1 <= '0;
      a_s2 <= '0;
      b_s1 <= '0;
      b_s2 <= '0;
    end else if (ce) begin
      d_s1 <= port_d_lines_in;
      d_s2 <= d_s1;
      e_s1 <= port_e_lines_in;
      e_s2 <= e_s1;
      a_s1 <= port_a_in;
      a_s2 <= a_s1;
      b_s1 <= port_b_in;
      b_s2 <= b_s1;
    end
  end

  // Holding registers; timed bits load only on the timer event
  logic [W-1:0] pd_hold, pe_hold;
  wire  [W-1:0] pd_load = timer_event ? {W{1'b1}} : ~pd_timed; // RULE3
  wire  [W-1:0] pe_load = timer_event ? {W{1'b1}} : ~pe_timed; // RULE3
  wire  [W-1:0] next_pd_hold = (pd_load & pd_data) | (~pd_load & pd_hold);
  wire  [W-1:0] next_pe_hold = (pe_load & pe_data) | (~pe_load & pe_hold);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pd_hold <= pdm_pkg::RST_DATA;
      pe_hold <= pdm_pkg::RST_DATA;
    end else if (ce) begin
      pd_hold <= next_pd_hold;
      pe_hold <= next_pe_hold;
    end
  end

  // Strobe decode: one eighth of the 64K I/O space per line
  function automatic logic strobe_hit(input logic [1:0] mode, input logic rd, input logic wr);
    case (mode)
      2'h0:    strobe_hit = 1'b1;
      2'h1:    strobe_hit = wr;
      2'h2:    strobe_hit = rd;
      2'h3:    strobe_hit = rd | wr;
      default: strobe_hit = 1'b0;
    endcase
  endfunction

  wire [2:0]   io_slot = io_addr[pdm_pkg::IO_ADDR_W-1:pdm_pkg::STB_SEL_LSB];
  logic [W-1:0] strobe_act;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      strobe_act[i] = io_cycle && (io_slot == i[2:0]) // RULE7
                      && strobe_hit(strobe_mode[2*i+:2], io_read, io_write); // RULE8
    end
  end

  // Port D pin drive
  logic [W-1:0] pd_val;
  always_comb begin
    pd_val = pd_hold;
    if (tx_a_alt_en) pd_val[pdm_pkg::TX_A_BIT] = tx_a; // RULE4 RULE25
    if (tx_b_alt_en) pd_val[pdm_pkg::TX_B_BIT] = tx_b; // RULE4 RULE25
  end
  wire [W-1:0] pd_drive = pd_dir; // RULE1
  // Open drain bits drive only a low level
  wire [W-1:0] next_pd_out = pd_val & ~pd_od; // RULE2
  wire [W-1:0] next_pd_oe  = pd_drive & (~pd_od | ~pd_val); // RULE2

  // Port E pin drive; strobe lines are active low
  wire [W-1:0] next_pe_out = (pe_strobe_en & ~strobe_act) | (~pe_strobe_en & pe_hold); // RULE6 RULE25
  wire [W-1:0] next_pe_oe  = pe_dir; // RULE1 RULE9

  // Slave data bus drive
  wire [W-1:0] next_pa_oe  = (slave_en && slave_dout_en) ? {W{1'b1}} : '0; // RULE23

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      port_d_lines_out <= '0;
      port_d_lines_oe  <= pdm_pkg::RST_DIR;
      port_e_lines_out <= '0;
      port_e_lines_oe  <= pdm_pkg::RST_DIR;
      port_a_out       <= '0;
      port_a_oe        <= '0;
    end else if (ce) begin
      port_d_lines_out <= next_pd_out;
      port_d_lines_oe  <= next_pd_oe;
      port_e_lines_out <= next_pe_out;
      port_e_lines_oe  <= next_pe_oe;
      port_a_out       <= slave_dout; // RULE23
      port_a_oe        <= next_pa_oe;
    end
  end

  // Slave select: pin level, or driven output level when bit 7 is an output
  wire sel_level = pe_dir[pdm_pkg::SEL_BIT] ? pe_hold[pdm_pkg::SEL_BIT] : e_s2[pdm_pkg::SEL_BIT]; // RULE12
  wire next_scs_n = slave_en ? sel_level : 1'b1; // RULE10

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      slave_attention_n    <= 1'b1;
      slave_chip_select_n  <= 1'b1;
      slave_read_strobe_n  <= 1'b1;
      slave_write_strobe_n <= 1'b1;
      slave_reg_addr       <= 2'h0;
      slave_data_in        <= '0;
    end else if (ce) begin
      slave_attention_n    <= ~(slave_en & slave_attention_req); // RULE19
      slave_chip_select_n  <= next_scs_n;
      slave_read_strobe_n  <= ~slave_en | b_s2[pdm_pkg::SRD_BIT]; // RULE20
      slave_write_strobe_n <= ~slave_en | b_s2[pdm_pkg::SWR_BIT]; // RULE21
      slave_reg_addr       <= {b_s2[pdm_pkg::SA1_BIT], b_s2[pdm_pkg::SA0_BIT]}; // RULE22
      slave_data_in        <= a_s2; // RULE23
    end
  end

  // Serial clocks and alternate receive
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serial_a_clock_pin_out <= 1'b0;
      serial_a_clock_pin_oe  <= 1'b0;
      serial_b_clock_pin_out <= 1'b0;
      serial_b_clock_pin_oe  <= 1'b0;
      serial_a_clock_in      <= 1'b0;
      serial_b_clock_in      <= 1'b0;
      rx_a                   <= 1'b1;
      rx_b                   <= 1'b1;
      port_d_read            <= '0;
      port_e_read            <= '0;
    end else if (ce) begin
      serial_a_clock_pin_out <= serial_a_clock_out; // RULE24
      serial_a_clock_pin_oe  <= sync_a_en & serial_a_clock_oe; // RULE24
      serial_b_clock_pin_out <= serial_b_clock_out; // RULE24
      serial_b_clock_pin_oe  <= sync_b_en & serial_b_clock_oe; // RULE24
      serial_a_clock_in      <= b_s2[pdm_pkg::CLK_A_BIT]; // RULE24
      serial_b_clock_in      <= b_s2[pdm_pkg::CLK_B_BIT]; // RULE24
      rx_a                   <= rx_a_alt_en ? d_s2[pdm_pkg::RX_A_BIT] : 1'b1; // RULE5
      rx_b                   <= rx_b_alt_en ? d_s2[pdm_pkg::RX_B_BIT] : 1'b1; // RULE5
      port_d_read            <= d_s2;
      port_e_read            <= e_s2;
    end
  end

  // External interrupts: per-pin edge latches, ORed per interrupt
  logic [3:0] src_pend;
  wire  [3:0] src_pin = {e_s2[pdm_pkg::IRQ1_B_BIT], e_s2[pdm_pkg::IRQ1_A_BIT],
                         e_s2[pdm_pkg::IRQ0_B_BIT], e_s2[pdm_pkg::IRQ0_A_BIT]}; // RULE13 RULE14
  wire  [3:0] src_clr = {irq1_ack, irq1_ack, irq0_ack, irq0_ack};

  for (genvar k = 0; k < 4; k++) begin : g_irq
    pdm_edge_latch u_latch (
      .clock    (clock),
      .rst      (rst),
      .ce       (ce),
      .pin_sync (src_pin[k]),
      .edge_sel (irq_src_en[k] ? irq_edge[2*k+:2] : pdm_pkg::EDGE_OFF), // RULE15
      .clear    (src_clr[k]),
      .pending  (src_pend[k])
    );
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq0_pending <= 1'b0;
      irq1_pending <= 1'b0;
    end else if (ce) begin
      irq0_pending <= src_pend[0] | src_pend[1]; // RULE16
      irq1_pending <= src_pend[2] | src_pend[3]; // RULE16
    end
  end

  a_strobe_low: assert property (@(posedge clock) disable iff (rst)
    ce && pe_strobe_en[0] && pe_dir[0] && io_cycle && io_slot == 3'h0 && strobe_mode[1:0] == 2'h0
    |=> !port_e_lines_out[0]) // RULE7
    else $error("strobe 0 not asserted");
  a_strobe_idle: assert property (@(posedge clock) disable iff (rst)
    ce && pe_strobe_en[1] && !io_cycle |=> port_e_lines_out[1]) // RULE8
    else $error("strobe active outside io cycle");
  a_tx_route: assert property (@(posedge clock) disable iff (rst)
    ce && tx_a_alt_en && pd_dir[pdm_pkg::TX_A_BIT] && !pd_od[pdm_pkg::TX_A_BIT]
    |=> port_d_lines_out[pdm_pkg::TX_A_BIT] == $past(tx_a)) // RULE4
    else $error("tx a not routed");
  a_open_drain: assert property (@(posedge clock) disable iff (rst)
    port_d_lines_oe[2] && $past(pd_od[2]) && $past(ce) |-> !port_d_lines_out[2]) // RULE2
    else $error("open drain drove high");
  a_dir_input: assert property (@(posedge clock) disable iff (rst)
    ce && !pe_dir[3] |=> !port_e_lines_oe[3]) // RULE1
    else $error("input bit driven");
  a_hold_timed: assert property (@(posedge clock) disable iff (rst)
    ce && pd_timed[0] && !timer_event |=> pd_hold[0] == $past(pd_hold[0])) // RULE3
    else $error("timed bit changed early");
  a_select_forced: assert property (@(posedge clock) disable iff (rst)
    ce && slave_en && pe_dir[7] && !pe_hold[7] |=> !slave_chip_select_n) // RULE12
    else $error("select not forced");
  a_attention: assert property (@(posedge clock) disable iff (rst)
    ce && !slave_en |=> slave_attention_n) // RULE19
    else $error("attention without slave port");
  a_irq_or: assert property (@(posedge clock) disable iff (rst)
    ce && src_pend[1] |=> irq0_pending) // RULE16
    else $error("source b not ORed");
endmodule
`default_nettype wire

// file: inc/pdm_pkg.sv
// Package with constants and types for the port D/E pin-function mux
package pdm_pkg;

  localparam int unsigned PORT_W       = 8;
  localparam logic [7:0]  RST_DATA     = 8'h00;
  localparam logic [7:0]  RST_DIR      = 8'h00;
  localparam logic [7:0]  RST_OD       = 8'h00;
  localparam logic [7:0]  RST_ALT      = 8'h00;
  localparam logic [1:0]  RST_EDGE     = 2'h0;
  localparam int unsigned IO_ADDR_W    = 16;
  localparam int unsigned STB_SEL_LSB  = 13;
  localparam int unsigned TX_A_BIT     = 6;
  localparam int unsigned TX_B_BIT     = 4;
  localparam int unsigned RX_A_BIT     = 7;
  localparam int unsigned RX_B_BIT     = 5;
  localparam int unsigned SEL_BIT      = 7;
  localparam int unsigned IRQ0_A_BIT   = 0;
  localparam int unsigned IRQ0_B_BIT   = 4;
  localparam int unsigned IRQ1_A_BIT   = 1;
  localparam int unsigned IRQ1_B_BIT   = 5;
  localparam int unsigned ATTN_BIT     = 7;
  localparam int unsigned SRD_BIT      = 3;
  localparam int unsigned SWR_BIT      = 2;
  localparam int unsigned SA0_BIT      = 4;
  localparam int unsigned SA1_BIT      = 5;
  localparam int unsigned CLK_A_BIT    = 1;
  localparam int unsigned CLK_B_BIT    = 0;

  // Edge selection of one interrupt input
  localparam logic [1:0]  EDGE_OFF     = 2'h0;
  localparam logic [1:0]  EDGE_FALL    = 2'h1;
  localparam logic [1:0]  EDGE_RISE    = 2'h2;
  localparam logic [1:0]  EDGE_BOTH    = 2'h3;

  // Strobe modes
  typedef enum logic [1:0] {
    PDM_STB_CS   = 2'h0,
    PDM_STB_WR   = 2'h1,
    PDM_STB_RD   = 2'h2,
    PDM_STB_RDWR = 2'h3
  } pdm_stb_mode_t;

endpackage

// file: tb/pdm_pin_model.sv
// Pin-level model of the devices and slave-port master outside the mux
`timescale 1ns/1ps
`default_nettype none
module pdm_pin_model (
  input  wire logic [7:0] d_out,
  input  wire logic [7:0] d_oe,
  input  wire logic [7:0] e_out,
  input  wire logic [7:0] e_oe,
  input  wire logic [7:0] a_out,
  input  wire logic [7:0] a_oe,
  input  wire logic       ca_out,
  input  wire logic       ca_oe,
  input  wire logic       cb_out,
  input  wire logic       cb_oe,
  input  wire logic [7:0] d_ext,
  input  wire logic [7:0] d_en,
  input  wire logic [7:0] e_ext,
  input  wire logic [7:0] e_en,
  input  wire logic [7:0] a_ext,
  input  wire logic [7:0] a_en,
  input  wire logic [5:0] b_ext,
  output logic      [7:0] d_pin,
  output logic      [7:0] e_pin,
  output logic      [7:0] a_pin,
  output logic      [5:0] b_pin
);
  // Lines nobody drives float up through pull-ups
  function automatic logic [7:0] lvl(input logic [7:0] o, oe, x, en);
    return (oe & o) | (~oe & en & x) | (~oe & ~en);
  endfunction
  assign d_pin = lvl(d_out, d_oe, d_ext, d_en);
  assign e_pin = lvl(e_out, e_oe, e_ext, e_en);
  assign a_pin = lvl(a_out, a_oe, a_ext, a_en);
  // Master strobes and address; serial clocks from the mux when it drives them, else from the peer
  assign b_pin = {b_ext[5:2], ca_oe ? ca_out : b_ext[1], cb_oe ? cb_out : b_ext[0]};
endmodule
`default_nettype wire

// file: tb/port_d_e_pin_function_mux_tb.sv
// Self-checking testbench for the port D/E pin-function mux
`timescale 1ns/1ps
`default_nettype none
module port_d_e_pin_function_mux_tb;
  logic clock, rst, ce, timer_event, tx_a_alt_en, tx_b_alt_en, tx_a, tx_b, rx_a_alt_en, rx_b_alt_en;
  logic io_cycle, io_read, io_write, irq0_ack, irq1_ack, slave_en, slave_attention_req, slave_dout_en;
  logic sync_a_en, sync_b_en, serial_a_clock_out, serial_a_clock_oe, serial_b_clock_out, serial_b_clock_oe;
  logic [7:0] pd_data, pd_dir, pd_od, pd_timed, pe_data, pe_dir, pe_timed, pe_strobe_en, slave_dout, irq_edge;
  logic [15:0] strobe_mode, io_addr;
  logic [3:0] irq_src_en;
  logic [7:0] port_d_lines_in, port_e_lines_in, port_a_in, d_ext, d_en, e_ext, e_en, a_ext, a_en;
  logic [5:0] port_b_in, b_ext;
  logic [7:0] port_d_lines_out, port_d_lines_oe, port_e_lines_out, port_e_lines_oe, port_a_out, port_a_oe;
  logic [7:0] port_d_read, port_e_read, slave_data_in;
  logic slave_attention_n, serial_a_clock_pin_out, serial_a_clock_pin_oe, serial_b_clock_pin_out;
  logic serial_b_clock_pin_oe, slave_chip_select_n, slave_read_strobe_n, slave_write_strobe_n;
  logic serial_a_clock_in, serial_b_clock_in, rx_a, rx_b, irq0_pending, irq1_pending;
  logic [1:0] slave_reg_addr;
  int bad_count;
  int comparisons;
  logic act;

  pdm_port_mux dut_u (.*);
  pdm_pin_model model_u (.d_out(port_d_lines_out), .d_oe(port_d_lines_oe), .e_out(port_e_lines_out),
    .e_oe(port_e_lines_oe), .a_out(port_a_out), .a_oe(port_a_oe), .ca_out(serial_a_clock_pin_out),
    .ca_oe(serial_a_clock_pin_oe), .cb_out(serial_b_clock_pin_out), .cb_oe(serial_b_clock_pin_oe),
    .d_ext(d_ext), .d_en(d_en), .e_ext(e_ext), .e_en(e_en), .a_ext(a_ext), .a_en(a_en), .b_ext(b_ext),
    .d_pin(port_d_lines_in), .e_pin(port_e_lines_in), .a_pin(port_a_in), .b_pin(port_b_in));

  always #25 clock = ~clock;

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic irq_try(input int b, input logic v, input logic [1:0] ex);
    e_ext[b] = v;
    step(5);
    chk("irq_pending", {6'h00, ex}, {6'h00, irq1_pending, irq0_pending});
    irq0_ack = 1'b1;
    irq1_ack = 1'b1;
    step(1);
    irq0_ack = 1'b0;
    irq1_ack = 1'b0;
    step(1);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    bad_count = 0;
    comparisons = 0;
    {clock, timer_event, tx_a_alt_en, tx_b_alt_en, tx_a, tx_b, rx_a_alt_en, rx_b_alt_en} = '0;
    {io_cycle, io_read, io_write, irq0_ack, irq1_ack, slave_en, slave_attention_req, slave_dout_en} = '0;
    {sync_a_en, sync_b_en, serial_a_clock_out, serial_a_clock_oe, serial_b_clock_out, serial_b_clock_oe} = '0;
    {pd_data, pd_dir, pd_od, pd_timed, pe_data, pe_dir, pe_timed, pe_strobe_en, slave_dout, irq_edge} = '0;
    {strobe_mode, io_addr, irq_src_en, a_ext, a_en} = '0;
    {d_ext, d_en, e_ext, e_en} = {4{8'hff}};
    b_ext = 6'h3f;
    rst = 1'b1;
    ce = 1'b1;
    step(2);
    chk("reset_d_oe", 8'h00, port_d_lines_oe);
    chk("reset_attention_n", 8'h01, {7'h00, slave_attention_n});
    step(3);
    rst = 1'b0;
    pd_dir = 8'ha5;
    pd_data = 8'hff;
    pe_dir = 8'h3c;
    pe_data = 8'hff;
    step(2);
    chk("d_oe", 8'ha5, port_d_lines_oe);
    chk("e_oe", 8'h3c, port_e_lines_oe);
    chk("d_out", 8'ha5, port_d_lines_out & port_d_lines_oe);
    pd_dir = 8'hff;
    pd_od = 8'h0f;
    pd_data = 8'h55;
    pe_dir = 8'hff;
    pe_data = 8'h55;
    step(2);
    chk("d_od_oe", 8'hfa, port_d_lines_oe);
    chk("d_od_out", 8'h50, port_d_lines_out & port_d_lines_oe);
    pd_od = 8'h00;
    pd_timed = 8'hff;
    pe_timed = 8'hff;
    step(1);
    pd_data = 8'haa;
    pe_data = 8'haa;
    step(3);
    chk("d_timed_hold", 8'h55, port_d_lines_out);
    chk("e_timed_hold", 8'h55, port_e_lines_out);
    timer_event = 1'b1;
    step(1);
    timer_event = 1'b0;
    step(2);
    chk("d_timed_load", 8'haa, port_d_lines_out);
    chk("e_timed_load", 8'haa, port_e_lines_out);
    {pd_timed, pe_timed} = '0;
    pd_data = 8'hff;
    tx_a_alt_en = 1'b1;
    tx_b_alt_en = 1'b1;
    tx_b = 1'b1;
    step(2);
    chk("d_tx", 8'hbf, port_d_lines_out);
    tx_a = 1'b1;
    tx_b = 1'b0;
    step(1);
    chk("d_tx", 8'hef, port_d_lines_out);
    pd_dir = 8'h5f;
    rx_a_alt_en = 1'b1;
    rx_b_alt_en = 1'b1;
    d_ext = 8'h7f;
    step(4);
    chk("rx", 8'h01, {6'h00, rx_a, rx_b});
    d_ext = 8'hdf;
    step(3);
    chk("rx", 8'h02, {6'h00, rx_a, rx_b});
    chk("d_read", 8'hcf, port_d_read);
    // Each line in turn, modes cycling, read then write then a foreign slot
    for (int i = 0; i < 8; i++) begin
      pe_strobe_en = 8'h01 << i;
      strobe_mode = 16'h0000;
      strobe_mode[2*i +: 2] = i[1:0];
      for (int op = 0; op < 3; op++) begin
        io_cycle = 1'b1;
        io_read = (op != 1);
        io_write = (op == 1);
        io_addr = {(op == 2) ? i[2:0] + 3'h1 : i[2:0], 13'h0000};
        act = (op != 2) && ((i % 4 == 0) || (i % 4 == 3) || (i % 4 == 1 && op == 1) || (i % 4 == 2 && op == 0));
        step(1);
        chk("strobe_n", {7'h00, ~act}, {7'h00, port_e_lines_out[i]});
      end
      io_cycle = 1'b0;
      step(1);
      chk("strobe_idle", 8'h01, {7'h00, port_e_lines_out[i]});
    end
    pe_strobe_en = 8'h00;
    slave_en = 1'b1;
    pe_dir = 8'h00;
    e_ext[7] = 1'b0;
    step(4);
    chk("chip_select_n", 8'h00, {7'h00, slave_chip_select_n});
    e_ext[7] = 1'b1;
    step(3);
    chk("chip_select_n", 8'h01, {7'h00, slave_chip_select_n});
    pe_dir = 8'h80;
    pe_data = 8'h00;
    step(3);
    chk("chip_select_n", 8'h00, {7'h00, slave_chip_select_n});
    slave_attention_req = 1'b1;
    slave_dout = 8'h3c;
    slave_dout_en = 1'b1;
    b_ext = 6'h27;
    step(3);
    chk("attention_n", 8'h00, {7'h00, slave_attention_n});
    chk("a_oe", 8'hff, port_a_oe);
    chk("a_out", 8'h3c, port_a_out);
    chk("rd_wr_addr", 8'h0a, {3'h0, slave_read_strobe_n, slave_write_strobe_n, 1'b0, slave_reg_addr});
    b_ext = 6'h1b;
    slave_dout_en = 1'b0;
    a_en = 8'hff;
    a_ext = 8'hc3;
    step(4);
    chk("rd_wr_addr", 8'h11, {3'h0, slave_read_strobe_n, slave_write_strobe_n, 1'b0, slave_reg_addr});
    chk("slave_data_in", 8'hc3, slave_data_in);
    sync_a_en = 1'b1;
    sync_b_en = 1'b1;
    serial_a_clock_oe = 1'b1;
    serial_a_clock_out = 1'b1;
    b_ext = 6'h3e;
    step(3);
    chk("clk_a_pin", 8'h03, {6'h00, serial_a_clock_pin_oe, serial_a_clock_pin_out});
    chk("clk_b_in", 8'h00, {7'h00, serial_b_clock_in});
    b_ext = 6'h3d;
    step(3);
    chk("clk_b_in", 8'h01, {7'h00, serial_b_clock_in});
    chk("clk_a_in", 8'h01, {7'h00, serial_a_clock_in});
    serial_b_clock_oe = 1'b1;
    step(4);
    chk("clk_b_pin", 8'h02, {6'h00, serial_b_clock_pin_oe, serial_b_clock_pin_out});
    chk("clk_b_in", 8'h00, {7'h00, serial_b_clock_in});
    pe_dir = 8'h00;
    irq_src_en = 4'hf;
    irq_edge = 8'h79;
    step(1);
    irq_try(0, 1'b0, 2'b01);
    irq_try(0, 1'b1, 2'b00);
    irq_try(4, 1'b0, 2'b00);
    irq_try(4, 1'b1, 2'b01);
    irq_try(1, 1'b0, 2'b10);
    irq_try(1, 1'b1, 2'b10);
    irq_try(5, 1'b0, 2'b10);
    irq_src_en = 4'he;
    irq_try(0, 1'b0, 2'b00);
    chk("e_read", 8'hde, port_e_read);
    // Clock enable low freezes the holding and output registers
    ce = 1'b0;
    pd_data = 8'h00;
    step(3);
    chk("d_frozen", 8'hef, port_d_lines_out);
    ce = 1'b1;
    step(2);
    chk("d_resumed", 8'h40, port_d_lines_out);
    print_verdict();
  end
endmodule
`default_nettype wire
